// ### hdl/power_mode_pkg.sv
/*
  Shared constants and types of the direct mode transition controller:
  register offsets, field positions, reset values, state counts, enums.
  Assumes one 100 MHz clock and an APB register bus with 8 address bits.
*/
package power_mode_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;   // Power mode control A
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;   // Power mode control B
  localparam logic [7:0] ADDR_INT_EN = 8'h08;   // Interrupt enable B
  localparam logic [7:0] ADDR_COND = 8'h0c;     // CPU condition code
  localparam logic [7:0] ADDR_STATUS = 8'h10;   // Mode and sequence state
  localparam logic [7:0] ADDR_EVENT = 8'h14;    // Sticky events, write 1 clears
  localparam logic [7:0] ADDR_MASK = 8'h18;     // Event mask

  // ==========================================================
  // Field positions
  localparam int CA_MA_POS = 0;     // Medium clock divider, 2 bits
  localparam int CA_LOW_SPEED_SELECT_POS = 2;   // Low speed select
  localparam int CA_TIMER_MODE_BIT3_POS = 3;   // Timer mode bit 3
  localparam int CA_STS_POS = 4;    // Oscillator wait select, 3 bits
  localparam int CA_STANDBY_SELECT_POS = 7;   // Standby select
  localparam int CB_DIRECT_CHANGE_ENABLE_POS = 0;   // Direct change enable
  localparam int CB_MEDIUM_SPEED_SELECT_POS = 1;   // Medium speed select
  localparam int CB_SA_POS = 2;     // Subactive divider, 2 bits
  localparam int IE_DT_POS = 0;     // Direct transition interrupt enable
  localparam int CC_I_POS = 7;      // Global interrupt mask
  localparam int EV_DT_POS = 0;     // Direct transition done
  localparam int EV_WAKE_POS = 1;   // Wake from halt

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] INT_EN_RST = 8'h00;
  localparam logic [7:0] COND_RST = 8'h80;      // Interrupts masked after reset
  localparam logic [1:0] EVENT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // ==========================================================
  // Timing counts, in states of the relevant CPU clock
  localparam logic [3:0] PD_INSN_STATES = 4'h2;   // Power-down instruction
  localparam logic [3:0] INT_PROC_STATES = 4'h1;  // Internal processing
  localparam logic [3:0] EXC_STATES = 4'he;       // Interrupt exception
  localparam int OSC_WAIT_STATES_DEF = 8192;      // Longest oscillator wait
  localparam logic [1:0] WATCH_DIV_LAST = 2'h3;   // Watch clock is pclk/4

  // ==========================================================
  // Types
  typedef enum logic [1:0] {mode_high, mode_medium, mode_sub} mode_t;
  typedef enum logic [2:0] {lp_none, lp_sleep, lp_subsleep, lp_watch, lp_standby} lp_t;
  typedef enum logic [2:0] {seq_run, seq_pd, seq_halt, seq_lock, seq_wait, seq_exc} seq_t;

endpackage : power_mode_pkg

// ### hdl/rate_if.sv
/*
  Carrier between the mode controller and its clock rate generator.
  Assumes both ends sit on pclk.
*/
`timescale 1ns/100ps
interface rate_if;
  import power_mode_pkg::*;
  mode_t mode;              // Current operating mode
  logic [1:0] med_div;      // Medium speed divider select
  logic [1:0] sub_div;      // Subactive divider select
  logic cpu_tick;           // CPU state enable
  logic periph_tick;        // Peripheral clock enable
  modport ctrl (output mode, med_div, sub_div, input cpu_tick, periph_tick);
  modport gen (input mode, med_div, sub_div, output cpu_tick, periph_tick);
endinterface : rate_if

// ### hdl/clk_rate_gen.sv
/*
  Clock rate generator: one-cycle enables for CPU and peripherals.
  Assumes pclk is the system oscillator; the watch clock is pclk/4.
*/
`timescale 1ns/100ps
module clk_rate_gen
  import power_mode_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Rate selection and enables
  rate_if.gen rif
);

  logic [5:0] med_cnt;   // Medium speed prescaler
  logic [1:0] wch_cnt;   // Watch clock prescaler
  logic [2:0] sub_cnt;   // Subactive prescaler on watch ticks
  logic med_tick;        // Medium speed enable
  logic wch_tick;        // Watch clock enable
  logic sub_tick;        // Subactive enable

  // ==========================================================
  // Helpers
  // Low-bit mask for a divide by (base << sel)
  function automatic logic [5:0] div_mask(input logic [5:0] base, input logic [1:0] sel);
    div_mask = 6'((base << sel) - 6'h01);
  endfunction : div_mask

  // ==========================================================
  // Prescalers
  // Free running so every rate stays phase aligned
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      med_cnt <= 6'h00;
      wch_cnt <= 2'h0;
      sub_cnt <= 3'h0;
    end
    else
    begin
      med_cnt <= med_cnt + 6'h01;
      wch_cnt <= wch_cnt + 2'h1;
      if (wch_tick)
        sub_cnt <= sub_cnt + 3'h1;
    end
  end

  // Medium speed is osc/8, /16, /32 or /64
  assign med_tick = (med_cnt & div_mask(6'h08, rif.med_div)) == 6'h00;
  assign wch_tick = wch_cnt == WATCH_DIV_LAST;
  // Subactive is watch/2, /4, /8; select 3 falls back to /8
  assign sub_tick = wch_tick &&
    ((sub_cnt & 3'(div_mask(6'h02, (rif.sub_div == 2'h3) ? 2'h2 : rif.sub_div))) == 3'h0);

  // ==========================================================
  // Enables per mode
  always_comb
  begin
    case (rif.mode)
      mode_high:
      begin
        rif.cpu_tick = 1'b1;
        rif.periph_tick = 1'b1;
      end
      mode_medium:
      begin
        rif.cpu_tick = med_tick;
        rif.periph_tick = med_tick;
      end
      mode_sub:
      begin
        rif.cpu_tick = sub_tick;
        rif.periph_tick = sub_tick;
      end
      default:
      begin
        rif.cpu_tick = 1'b1;
        rif.periph_tick = 1'b1;
      end
    endcase
  end

endmodule : clk_rate_gen

// ### hdl/direct_mode_transition_ctrl.sv
/*
  Power mode controller with direct transitions between active and
  subactive operation, plus the ordinary halt entries as fallback.
  Assumes the CPU pulses sleep_insn on pclk, a wake pin from outside,
  and APB software access to the control registers.
*/
//
// Behaviour
// - Direct enable: change mode without halting program
// - Completed change starts dedicated interrupt exception
// - Interrupt disabled: plain sleep or watch instead
// - Global mask set: stuck in sleep/watch forever
// - High to medium via sleep
// - Medium to high via sleep
// - Active to subactive via watch
// - Subactive to high after oscillator wait
// - Subactive to medium after oscillator wait
// - Old clock 2+1 states, new clock 14
// - Oscillator wait plus 14, new clock
// - Speed change within active mode allowed
// - Medium mode peripherals at selected divider
// - Subactive clock is watch/2, /4, /8
`timescale 1ns/100ps
module direct_mode_transition_ctrl
  import power_mode_pkg::*;
#(
  parameter int unsigned OSC_WAIT_STATES = OSC_WAIT_STATES_DEF
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU side
  input wire logic sleep_insn,
  input wire logic wake_pin,
  output logic cpu_run,
  output logic cpu_tick,
  output logic periph_tick,
  output logic exc_start,
  output logic [2:0] power_state,
  output logic [1:0] cur_mode_out,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Declarations
  logic [7:0] ctrl_a;          // power_mode_ctrl_reg_a
  logic [7:0] ctrl_b;          // power_mode_ctrl_reg_b
  logic [7:0] int_en;          // interrupt_enable_reg_b
  logic [7:0] cond;            // cpu_condition_code_reg
  logic [1:0] event_stat;      // Sticky events
  logic [1:0] event_mask;      // Event mask
  logic wr_acc;                // APB write access phase
  logic wake_meta;             // Wake synchroniser, first stage
  logic wake_sync;             // Wake synchroniser, second stage
  seq_t seq;                   // Sequence state
  mode_t cur_mode;             // Current operating mode
  mode_t tgt_mode;             // Mode after the transition
  lp_t lp;                     // Halt kind held or passed through
  logic is_direct;             // Transition in progress is direct
  logic [3:0] pd_cnt;          // Old-clock states left
  logic [31:0] wait_cnt;       // Oscillator wait states left
  logic [3:0] exc_cnt;         // Exception states left
  logic set_dt;                // Direct change done event
  logic set_wake;              // Wake event
  // Decoded sleep outcome
  logic next_direct;
  mode_t next_tgt;
  lp_t next_lp;
  logic [31:0] wait_len;

  // Field views
  logic direct_change_enable, medium_speed_select, standby_select, low_speed_select, timer_mode_bit3, ibit, ie_dt;
  logic [2:0] sts;

  rate_if rif ();

  assign direct_change_enable = ctrl_b[CB_DIRECT_CHANGE_ENABLE_POS];
  assign medium_speed_select = ctrl_b[CB_MEDIUM_SPEED_SELECT_POS];
  assign standby_select = ctrl_a[CA_STANDBY_SELECT_POS];
  assign low_speed_select = ctrl_a[CA_LOW_SPEED_SELECT_POS];
  assign timer_mode_bit3 = ctrl_a[CA_TIMER_MODE_BIT3_POS];
  assign sts = ctrl_a[CA_STS_POS +: 3];
  assign ibit = cond[CC_I_POS];
  assign ie_dt = int_en[IE_DT_POS];

  // ==========================================================
  // Clock rates
  assign rif.mode = cur_mode;
  assign rif.med_div = ctrl_a[CA_MA_POS +: 2];
  assign rif.sub_div = ctrl_b[CB_SA_POS +: 2];

  clk_rate_gen u_rate (
    .pclk (pclk),
    .presetn (presetn),
    .rif (rif)
  );

  assign cpu_tick = rif.cpu_tick;
  assign periph_tick = rif.periph_tick;

  // Wait select halves the longest wait per step
  assign wait_len = (OSC_WAIT_STATES >> sts) == 0 ? 32'h1 : 32'(OSC_WAIT_STATES >> sts);

  // ==========================================================
  // Wake pin synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end
    else
    begin
      wake_meta <= wake_pin;
      wake_sync <= wake_meta;
    end
  end

  // ==========================================================
  // Sleep decode
  // Direct changes need the interrupt enabled; otherwise halt
  always_comb
  begin
    next_direct = 1'b0;
    next_tgt = cur_mode;
    next_lp = lp_sleep;
    case (cur_mode)
      mode_high, mode_medium:
      begin
        if (!standby_select && !low_speed_select)
        begin
          next_lp = lp_sleep;
          next_tgt = medium_speed_select ? mode_medium : mode_high;
          next_direct = direct_change_enable && (next_tgt != cur_mode);
        end
        else if (standby_select && timer_mode_bit3 && low_speed_select)
        begin
          next_lp = lp_watch;
          next_tgt = mode_sub;
          next_direct = direct_change_enable;
        end
        else if (!standby_select)
          next_lp = lp_sleep;
        else
          next_lp = lp_standby;
      end
      mode_sub:
      begin
        if (standby_select && timer_mode_bit3)
        begin
          next_lp = lp_watch;
          next_tgt = medium_speed_select ? mode_medium : mode_high;
          next_direct = direct_change_enable && !low_speed_select;
        end
        else if (!standby_select)
          next_lp = lp_subsleep;
        else
          next_lp = lp_standby;
      end
      default:
      begin
        next_lp = lp_sleep;
      end
    endcase
    if (!ie_dt)
      next_direct = 1'b0;
  end

  // ==========================================================
  // Transition sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq <= seq_run;
      cur_mode <= mode_high;
      tgt_mode <= mode_high;
      lp <= lp_none;
      is_direct <= 1'b0;
      pd_cnt <= 4'h0;
      wait_cnt <= 32'h0;
      exc_cnt <= 4'h0;
      set_dt <= 1'b0;
      set_wake <= 1'b0;
      exc_start <= 1'b0;
    end
    else
    begin
      set_dt <= 1'b0;
      set_wake <= 1'b0;
      exc_start <= 1'b0;
      case (seq)
        // Running: power-down instruction starts a sequence
        seq_run:
        begin
          if (sleep_insn)
          begin
            seq <= seq_pd;
            pd_cnt <= PD_INSN_STATES + INT_PROC_STATES;
            is_direct <= next_direct;
            tgt_mode <= next_tgt;
            lp <= next_lp;
          end
        end
        // Instruction and internal states on the old clock
        seq_pd:
        begin
          if (cpu_tick)
          begin
            pd_cnt <= pd_cnt - 4'h1;
            if (pd_cnt == 4'h1)
            begin
              if (!is_direct)
                seq <= seq_halt;
              else if (ibit)
                seq <= seq_lock;
              else
              begin
                cur_mode <= tgt_mode;
                if (cur_mode == mode_sub)
                begin
                  seq <= seq_wait;
                  wait_cnt <= wait_len;
                end
                else
                begin
                  seq <= seq_exc;
                  exc_cnt <= EXC_STATES;
                  exc_start <= 1'b1;
                  set_dt <= 1'b1;
                end
              end
            end
          end
        end
        // Ordinary halt; only an unmasked wake leaves it
        seq_halt:
        begin
          if (wake_sync && !ibit)
          begin
            set_wake <= 1'b1;
            if (lp == lp_sleep || lp == lp_subsleep || (lp == lp_watch && low_speed_select))
            begin
              if (lp == lp_watch)
                cur_mode <= mode_sub;
              seq <= seq_exc;
              exc_cnt <= EXC_STATES;
              exc_start <= 1'b1;
            end
            else
            begin
              // Oscillator restarts before active operation
              cur_mode <= medium_speed_select ? mode_medium : mode_high;
              seq <= seq_wait;
              wait_cnt <= wait_len;
            end
          end
        end
        // Masked direct attempt: no way out but reset
        seq_lock:
        begin
          seq <= seq_lock;
        end
        // Oscillator settling on the new system clock
        seq_wait:
        begin
          if (cpu_tick)
          begin
            wait_cnt <= wait_cnt - 32'h1;
            if (wait_cnt == 32'h1)
            begin
              seq <= seq_exc;
              exc_cnt <= EXC_STATES;
              exc_start <= 1'b1;
              set_dt <= is_direct;
            end
          end
        end
        // Exception states on the new clock
        seq_exc:
        begin
          if (cpu_tick)
          begin
            exc_cnt <= exc_cnt - 4'h1;
            if (exc_cnt == 4'h1)
            begin
              seq <= seq_run;
              lp <= lp_none;
              is_direct <= 1'b0;
            end
          end
        end
        default:
        begin
          seq <= seq_run;
        end
      endcase
    end
  end

  // CPU executes except while halted, locked or in the oscillator wait after an ordinary halt
  assign cpu_run = (seq != seq_halt) && (seq != seq_lock) && (seq != seq_wait || is_direct);
  assign power_state = (seq == seq_run) ? 3'(lp_none) : 3'(lp);
  assign cur_mode_out = 2'(cur_mode);

  // ==========================================================
  // APB register file
  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;   // Zero wait states

  // Control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_a <= CTRL_A_RST;
      ctrl_b <= CTRL_B_RST;
      int_en <= INT_EN_RST;
      cond <= COND_RST;
      event_mask <= MASK_RST;
    end
    else if (wr_acc)
    begin
      case (paddr)
        ADDR_CTRL_A: ctrl_a <= pwdata[7:0];
        ADDR_CTRL_B: ctrl_b <= {4'h0, pwdata[3:0]};
        ADDR_INT_EN: int_en <= {7'h00, pwdata[0]};
        ADDR_COND: cond <= {pwdata[7], 7'h00};
        ADDR_MASK: event_mask <= pwdata[1:0];
        default:
        begin
          // Read-only or unmapped
        end
      endcase
    end
  end

  // Sticky events; a set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_stat <= EVENT_RST;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == EV_DT_POS && set_dt) || (i == EV_WAKE_POS && set_wake))
          event_stat[i] <= 1'b1;
        else if (wr_acc && paddr == ADDR_EVENT && pwdata[i])
          event_stat[i] <= 1'b0;
      end
    end
  end

  assign irq = |(event_stat & event_mask);

  // Read mux and error answer
  always_comb
  begin
    prdata = 32'h0;
    pslverr = 1'b0;
    case (paddr)
      ADDR_CTRL_A: prdata = {24'h0, ctrl_a};
      ADDR_CTRL_B: prdata = {24'h0, ctrl_b};
      ADDR_INT_EN: prdata = {24'h0, int_en};
      ADDR_COND: prdata = {24'h0, cond};
      ADDR_STATUS: prdata = {24'h0, 3'(seq), 3'(lp), 2'(cur_mode)};
      ADDR_EVENT: prdata = {30'h0, event_stat};
      ADDR_MASK: prdata = {30'h0, event_mask};
      default: pslverr = psel && penable;
    endcase
  end

endmodule : direct_mode_transition_ctrl

// ### test/direct_mode_transition_ctrl_chk.sv
/*
  Port checker for the direct mode transition controller.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module direct_mode_transition_ctrl_chk
  import power_mode_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // CPU side
  input wire logic cpu_run,
  input wire logic cpu_tick,
  input wire logic periph_tick,
  input wire logic exc_start,
  input wire logic [2:0] power_state,
  input wire logic [1:0] cur_mode_out
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Rate windows: slow modes never tick twice within 8 cycles
  sequence quiet_sub;
    (!cpu_tick || cur_mode_out != 2'h2) [*7];
  endsequence
  sequence quiet_med;
    (!periph_tick || cur_mode_out != 2'h1) [*7];
  endsequence

  // ==========================================================
  // Bus answers
  ready_const_a: assert property (pready) else $error("pready low");
  bad_addr_a: assert property (psel && penable && paddr > ADDR_MASK |-> pslverr) else $error("no slave error");
  // ==========================================================
  // Sequencing
  run_idle_a: assert property (power_state == 3'h0 |-> cpu_run) else $error("idle but halted");
  mode_busy_a: assert property ($changed(cur_mode_out) |-> $past(power_state) != 3'h0) else $error("mode moved");
  exc_pulse_a: assert property (exc_start |-> cpu_run ##1 !exc_start) else $error("bad exception pulse");
  change_exc_a: assert property ($changed(cur_mode_out) && $past(cpu_run) && $past(cur_mode_out) != 2'h2
    |-> exc_start) else $error("change without exception");
  high_tick_a: assert property (cur_mode_out == 2'h0 && power_state == 3'h0 |-> cpu_tick)
    else $error("high speed tick missing");
  med_rate_a: assert property (cur_mode_out == 2'h1 && periph_tick |=> quiet_med) else $error("medium too fast");
  sub_rate_a: assert property (cur_mode_out == 2'h2 && cpu_tick |=> quiet_sub) else $error("subactive too fast");
endmodule : direct_mode_transition_ctrl_chk

// ### test/tb_direct_mode_transition_ctrl.sv
/*
  Self-checking bench for the direct mode transition controller.
  Assumes a 100 MHz pclk and a shortened oscillator wait of 16.
*/
`timescale 1ns/100ps
module tb_direct_mode_transition_ctrl;
  import power_mode_pkg::*;
  // ==========================================================
  // Signals
  localparam int OSC_WAIT = 16; // Short wait keeps the run brief
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sleep_insn = 1'b0;
  logic wake_pin = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, cpu_run, cpu_tick, periph_tick, exc_start, irq;
  logic [2:0] power_state;
  logic [1:0] cur_mode_out;
  int n_mismatch = 0;
  int cmp_count = 0;

  direct_mode_transition_ctrl #(.OSC_WAIT_STATES(OSC_WAIT)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_insn(sleep_insn), .wake_pin(wake_pin), .cpu_run(cpu_run),
    .cpu_tick(cpu_tick), .periph_tick(periph_tick), .exc_start(exc_start), .power_state(power_state),
    .cur_mode_out(cur_mode_out), .irq(irq));

  // Free-running clock
  always #5 pclk = ~pclk;

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    check(rd, exp, "read data");
    check(err, exp_err, "slave error");
  endtask : rdchk

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // One-cycle power-down instruction
  task automatic run_sleep;
    @(posedge pclk);
    sleep_insn <= 1'b1;
    @(posedge pclk);
    sleep_insn <= 1'b0;
  endtask : run_sleep

  // Direct change: ticks up to the exception, mode, then 14 exception ticks
  task automatic direct(input logic [1:0] m, input int pd, input string what);
    int n;
    logic [31:0] t;   // Four-state, so an unknown tick shows up
    logic run_ok;
    run_sleep();
    t = 0;
    n = 0;
    run_ok = 1'b1;
    do
    begin
      @(negedge pclk);
      n++;
      if (exc_start !== 1'b1)
      begin
        t += cpu_tick;
        run_ok &= cpu_run;
      end
    end
    while (exc_start !== 1'b1 && n < 3000);
    check(exc_start, 1'b1, what);
    check(t, pd, what);
    check(cur_mode_out, m, what);
    check(run_ok, 1'b1, what);
    t = 0;
    while (power_state !== 3'h0 && n < 6000)
    begin
      t += cpu_tick;
      @(negedge pclk);
      n++;
    end
    check(t, EXC_STATES, what);
    $display("Test %s done", what);
  endtask : direct

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rdchk(ADDR_CTRL_A, CTRL_A_RST, 1'b0);
    rdchk(ADDR_CTRL_B, CTRL_B_RST, 1'b0);
    rdchk(ADDR_INT_EN, INT_EN_RST, 1'b0);
    rdchk(ADDR_COND, COND_RST, 1'b0);
    rdchk(ADDR_EVENT, EVENT_RST, 1'b0);
    rdchk(ADDR_MASK, MASK_RST, 1'b0);
    wr(ADDR_STATUS, 32'hff);
    rdchk(ADDR_STATUS, 32'h0, 1'b0);
    rdchk(8'h1c, 32'h0, 1'b1);
    $display("Test regs done");
  endtask : t_regs

  // Global mask set: halted for good, only reset recovers
  task automatic t_lock;
    wr(ADDR_INT_EN, 32'h1);
    wr(ADDR_CTRL_B, 32'h3);
    run_sleep();
    repeat (20) @(negedge pclk);
    wake_pin <= 1'b1;
    repeat (100) @(negedge pclk);
    check(cpu_run, 1'b0, "lock run");
    check(power_state, 3'h1, "lock state");
    check(cur_mode_out, 2'h0, "lock mode");
    @(posedge pclk);
    wake_pin <= 1'b0;
    do_reset();
    @(negedge pclk);
    check(cpu_run, 1'b1, "reset run");
    $display("Test lock done");
  endtask : t_lock

  task automatic t_direct;
    wr(ADDR_COND, 32'h0);
    wr(ADDR_INT_EN, 32'h1);
    wr(ADDR_MASK, 32'h1);
    wr(ADDR_CTRL_B, 32'h3);
    direct(2'h1, 3, "high_to_med");
    check(irq, 1'b1, "irq set");
    rdchk(ADDR_STATUS, 32'h1, 1'b0);
    wr(ADDR_EVENT, 32'h1);
    @(negedge pclk);   // Clear lands at the access edge
    check(irq, 1'b0, "irq cleared");
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_CTRL_B, 32'h1);
    direct(2'h0, 3, "med_to_high");
    check(irq, 1'b0, "irq masked");
    rdchk(ADDR_EVENT, 32'h1, 1'b0);
    wr(ADDR_EVENT, 32'h1);
    wr(ADDR_CTRL_A, 32'h8c);
    direct(2'h2, 3, "high_to_sub");
    wr(ADDR_CTRL_A, 32'h98);
    direct(2'h0, 3 + (OSC_WAIT >> 1), "sub_to_high");
    wr(ADDR_CTRL_A, 32'h0);
    wr(ADDR_CTRL_B, 32'h3);
    direct(2'h1, 3, "high_to_med2");
    wr(ADDR_CTRL_A, 32'h8c);
    direct(2'h2, 3, "med_to_sub");
    wr(ADDR_CTRL_A, 32'h98);
    direct(2'h1, 3 + (OSC_WAIT >> 1), "sub_to_med");
    $display("Test direct done");
  endtask : t_direct

  // Fallback halts, woken by the pin, all with the interrupt disabled; first row would otherwise be direct
  // Last row halts in subsleep from subactive
  task automatic t_fallback;
    logic [7:0] ca [6] = '{8'h00, 8'h00, 8'h00, 8'h88, 8'h8c, 8'h00};
    logic [7:0] cb [6] = '{8'h03, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    logic [2:0] ps [6] = '{3'h1, 3'h1, 3'h1, 3'h4, 3'h3, 3'h2};
    logic [1:0] md [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2};
    int n;
    wr(ADDR_CTRL_A, 32'h0);
    wr(ADDR_CTRL_B, 32'h1);
    direct(2'h0, 3, "med_to_high_pre");
    wr(ADDR_INT_EN, 32'h0);
    wr(ADDR_MASK, 32'h2);
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_EVENT, 32'h3);
      wr(ADDR_CTRL_A, {24'h0, ca[i]});
      wr(ADDR_CTRL_B, {24'h0, cb[i]});
      run_sleep();
      n = 0;
      while (cpu_run !== 1'b0 && n < 50)
      begin
        @(negedge pclk);
        n++;
      end
      check(power_state, ps[i], "halt kind");
      check(cur_mode_out, (i == 0) ? 2'h0 : md[i - 1], "mode kept");
      @(posedge pclk);
      wake_pin <= 1'b1;
      while (power_state !== 3'h0 && n < 3000)
      begin
        @(negedge pclk);
        n++;
      end
      check(irq, 1'b1, "wake irq");
      @(posedge pclk);
      wake_pin <= 1'b0;
      check(cur_mode_out, md[i], "wake mode");
      rdchk(ADDR_EVENT, 32'h2, 1'b0);
    end
    $display("Test fallback done");
  endtask : t_fallback

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    do_reset();
    t_regs();
    t_lock();
    t_direct();
    t_fallback();
    final_report();
  end

  initial
  begin
    #900000;
    n_mismatch++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end
endmodule : tb_direct_mode_transition_ctrl

bind direct_mode_transition_ctrl direct_mode_transition_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .cpu_run, .cpu_tick, .periph_tick, .exc_start, .power_state, .cur_mode_out);
